// ### verilog/pcs_clock_ctrl.sv
// pll clock select control with protected register writes
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"
module pcs_clock_ctrl
	import pcs_pkg::*;
#(
	parameter int LOCK_CYC = `PCS_LOCK_CYC
) (
	input  wire logic             clk_sys,         // system clock
	input  wire logic             reset_n,         // async reset, low
	input  wire logic             clk_en,          // freezes all state
	input  wire logic [`PCS_AW-1:0] reg_addr,      // register address
	input  wire logic [7:0]       reg_wdata,       // write data
	input  wire logic             reg_wr,          // write strobe
	input  wire logic             reg_rd,          // read strobe
	output logic      [7:0]       reg_rdata,       // read data, next cycle
	output logic                  pll_run,         // pll oscillating
	output logic                  sys_clk_src_pll, // 1 pll, 0 oscillator
	output logic                  pll_mult8,       // 1 x8, 0 x4
	output logic      [2:0]       cpu_clk_div,     // divide by 2**n
	output logic                  cpu_on_subclk,   // cpu on subclock
	output logic                  main_osc_stop,   // main oscillator off
	output logic                  main_fb_disable, // main feedback off
	output logic                  subclock_feedback_disable // sub fb off
);
	pcs_prot_e prot_st_ff;
	pcs_byte_t cmd_val_ff;
	pcs_byte_t pll_control_ff;
	pcs_byte_t pll_multiplier_control_ff;
	pcs_byte_t processor_clock_control_ff;
	pcs_byte_t reg_rdata_ff;
	pcs_byte_t nxt_rdata;
	logic      clock_status_bit_ff;
	logic      prot_err_ff;
	logic      pll_run_ff;
	logic      src_pll_ff;
	logic      mult8_ff;
	logic [2:0] cpu_div_ff;
	logic      sub_ff;
	logic      osc_stop_ff;
	logic      mfb_dis_ff;
	logic      sfb_dis_ff;
	logic      locked;
	logic      wr_ctl;
	logic      wr_mul;
	logic      wr_pcc;
	logic      wr_cmd;
	logic      wr_stat;
	logic      unlock_ok;
	logic      mul_we;
	logic      pcc_we;
	logic      prot_bad;

	// address decode shared by the write strobes and the checks; the read path uses its own case
	function automatic logic hit(
		input logic [`PCS_AW-1:0] a,
		input logic [`PCS_AW-1:0] r
	);
		return a == r;
	endfunction

	// write strobes per register
	assign wr_ctl  = reg_wr && hit(reg_addr, `PCS_A_CTL);
	assign wr_mul  = reg_wr && hit(reg_addr, `PCS_A_MUL);
	assign wr_pcc  = reg_wr && hit(reg_addr, `PCS_A_PCC);
	assign wr_cmd  = reg_wr && hit(reg_addr, `PCS_A_CMD);
	assign wr_stat = reg_wr && hit(reg_addr, `PCS_A_STAT);

	// a protected store must be the very next write, with the same byte
	assign unlock_ok = (prot_st_ff == PCS_PROT_ARMED)
		&& (reg_wdata == cmd_val_ff);
	assign mul_we    = wr_mul && unlock_ok;
	assign pcc_we    = wr_pcc && unlock_ok;
	assign prot_bad  = (wr_mul || wr_pcc) && !unlock_ok;

	// protection sequencer: armed by the command store, spent by any other write
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prot_st_ff <= PCS_PROT_IDLE;
			cmd_val_ff <= `PCS_ZERO8;
		end else if (clk_en) begin
			if (wr_cmd) begin
				prot_st_ff <= PCS_PROT_ARMED;
				cmd_val_ff <= reg_wdata;
			end else if (reg_wr) begin
				prot_st_ff <= PCS_PROT_IDLE;
			end
		end
	end

	// pll control: run and select bits, reserved bits held at zero
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pll_control_ff <= `PCS_CTL_RST;
		end else if (clk_en && wr_ctl) begin
			pll_control_ff <= reg_wdata & `PCS_CTL_WMASK;
		end
	end

	// multiplier control, protected
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pll_multiplier_control_ff <= `PCS_MUL_RST;
		end else if (clk_en && mul_we) begin
			pll_multiplier_control_ff <= reg_wdata;
		end
	end

	// processor clock control, protected; status bit never stored
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			processor_clock_control_ff <= `PCS_PCC_RST;
		end else if (clk_en && pcc_we) begin
			processor_clock_control_ff <=
				reg_wdata & `PCS_PCC_WMASK;
		end
	end

	// clock status follows the cpu source once the switch has happened
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clock_status_bit_ff <= 1'b0;
		end else if (clk_en) begin
			clock_status_bit_ff <=
				processor_clock_control_ff[`PCS_PCC_SUB];
		end
	end

	// sticky flag for a protected store that broke the sequence
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prot_err_ff <= 1'b0;
		end else if (clk_en) begin
			if (prot_bad) begin
				prot_err_ff <= 1'b1;                   // set wins over clear
			end else if (wr_stat && reg_wdata[`PCS_STAT_ERR]) begin
				prot_err_ff <= 1'b0;
			end
		end
	end

	// lock timer restarts whenever the pll is switched off
	pcs_lock_timer #(
		.LOCK_CYC (LOCK_CYC)
	) u_lock (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.pll_on  (pll_control_ff[`PCS_CTL_ON]),
		.locked  (locked)
	);

	// pll and clock tree controls, registered
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pll_run_ff <= 1'b1;
			src_pll_ff <= 1'b0;
			mult8_ff   <= 1'b0;
		end else if (clk_en) begin
			pll_run_ff <= pll_control_ff[`PCS_CTL_ON];
			src_pll_ff <= pll_control_ff[`PCS_CTL_SEL];
			mult8_ff   <= (pll_multiplier_control_ff
				== `PCS_MUL_X8);
		end
	end

	// cpu divider and oscillator controls, registered
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cpu_div_ff  <= 3'(`PCS_PCC_RST);
			sub_ff      <= 1'b0;
			osc_stop_ff <= 1'b0;
			mfb_dis_ff  <= 1'b0;
			sfb_dis_ff  <= 1'b0;
		end else if (clk_en) begin
			cpu_div_ff  <=
				processor_clock_control_ff[`PCS_PCC_DIVH:0];
			sub_ff      <= processor_clock_control_ff[`PCS_PCC_SUB];
			osc_stop_ff <= processor_clock_control_ff[`PCS_PCC_MCK];
			mfb_dis_ff  <= processor_clock_control_ff[`PCS_PCC_MFRC];
			sfb_dis_ff  <= processor_clock_control_ff[`PCS_PCC_FRC];
		end
	end

	// read mux; unmapped and command addresses read as zero
	always_comb begin
		nxt_rdata = `PCS_ZERO8;
		case (reg_addr)
			`PCS_A_CTL: begin
				nxt_rdata = pll_control_ff;
			end
			`PCS_A_LOCK: begin
				nxt_rdata = locked ? `PCS_LOCK_DONE : `PCS_LOCK_WAIT;
			end
			`PCS_A_MUL: begin
				nxt_rdata = pll_multiplier_control_ff;
			end
			`PCS_A_PCC: begin
				nxt_rdata = processor_clock_control_ff;
				nxt_rdata[`PCS_PCC_CLS] = clock_status_bit_ff;
			end
			`PCS_A_STAT: begin
				nxt_rdata[`PCS_STAT_ERR] = prot_err_ff;
			end
			default: begin
				nxt_rdata = `PCS_ZERO8;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_ff <= `PCS_ZERO8;
		end else if (clk_en) begin
			reg_rdata_ff <= reg_rd ? nxt_rdata : `PCS_ZERO8;
		end
	end

	assign reg_rdata                 = reg_rdata_ff;
	assign pll_run                   = pll_run_ff;
	assign sys_clk_src_pll           = src_pll_ff;
	assign pll_mult8                 = mult8_ff;
	assign cpu_clk_div               = cpu_div_ff;
	assign cpu_on_subclk             = sub_ff;
	assign main_osc_stop             = osc_stop_ff;
	assign main_fb_disable           = mfb_dis_ff;
	assign subclock_feedback_disable = sfb_dis_ff;

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_ctl_reset_val: assert property (
		$rose(reset_n) |-> pll_control_ff == `PCS_CTL_RST)
		else $error("pll control not at reset value");
	a_reset_through: assert property (
		$rose(reset_n) |-> pll_run_ff && !src_pll_ff)
		else $error("wrong pll state after reset");
	a_lock_read: assert property (
		clk_en && reg_rd && hit(reg_addr, `PCS_A_LOCK)
		|=> reg_rdata == ($past(locked) ? `PCS_LOCK_DONE : `PCS_LOCK_WAIT))
		else $error("lock flag read wrong");
	a_lock_no_write: assert property (
		clk_en && reg_wr && hit(reg_addr, `PCS_A_LOCK)
		|=> $stable(pll_control_ff) && $stable(pll_multiplier_control_ff)
		&& $stable(processor_clock_control_ff))
		else $error("lock write altered a register");
	a_mul_reset_val: assert property (
		$rose(reset_n) |-> pll_multiplier_control_ff == `PCS_MUL_RST)
		else $error("multiplier not at reset value");
	a_mul_guarded: assert property (
		clk_en && wr_mul && !unlock_ok |=> $stable(pll_multiplier_control_ff))
		else $error("unprotected multiplier write taken");
	a_mul_unlocked: assert property (
		clk_en && wr_cmd ##1 clk_en && wr_mul && reg_wdata == $past(reg_wdata)
		|=> pll_multiplier_control_ff == $past(reg_wdata))
		else $error("protected multiplier write lost");
	a_mult_factor: assert property (
		clk_en |=> mult8_ff == ($past(pll_multiplier_control_ff) == `PCS_MUL_X8))
		else $error("multiplier factor wrong");
	a_sel_source: assert property (
		clk_en |=> src_pll_ff == $past(pll_control_ff[`PCS_CTL_SEL]))
		else $error("clock source not following select");
	a_sel_drop: assert property (
		clk_en && wr_ctl && !reg_wdata[`PCS_CTL_SEL] ##1 clk_en |=> !src_pll_ff)
		else $error("clock-through not taken");
	a_cls_ro: assert property (
		clk_en && pcc_we |=> !processor_clock_control_ff[`PCS_PCC_CLS])
		else $error("status bit written");
	a_pcc_undiv: assert property (
		clk_en && processor_clock_control_ff == `PCS_PCC_UNDIV
		|=> cpu_div_ff == 3'h0 && sfb_dis_ff && !sub_ff)
		else $error("undivided setting not applied");
	a_pcc_reset_val: assert property (
		$rose(reset_n) |-> processor_clock_control_ff == `PCS_PCC_RST)
		else $error("processor clock control not at reset");
	a_freeze_state: assert property (
		!clk_en |=> $stable(pll_control_ff) && $stable(reg_rdata_ff))
		else $error("state moved with clock enable low");
	a_err_sticky: assert property (
		clk_en && prot_bad |=> prot_err_ff)
		else $error("refused protected store not flagged");

	c_mul_x8: cover property (mul_we && reg_wdata == `PCS_MUL_X8);
	c_pll_mode: cover property (locked && src_pll_ff && mult8_ff);
	c_bad_store: cover property (prot_bad);
	c_undiv: cover property (processor_clock_control_ff == `PCS_PCC_UNDIV);
endmodule // pcs_clock_ctrl
`default_nettype wire

// ### include/pcs_cfg.svh
// constants of the pll clock select control block
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// register addresses on the plain register port
`define PCS_AW        3
`define PCS_A_CTL     3'h0
`define PCS_A_LOCK    3'h1
`define PCS_A_MUL     3'h2
`define PCS_A_PCC     3'h3
`define PCS_A_CMD     3'h4
`define PCS_A_STAT    3'h5

// reset and special values
`define PCS_ZERO8     8'h00
`define PCS_CTL_RST   8'h01
`define PCS_CTL_WMASK 8'h03
`define PCS_LOCK_WAIT 8'h01
`define PCS_LOCK_DONE 8'h00
`define PCS_MUL_RST   8'h0A
`define PCS_MUL_X8    8'h0B
`define PCS_PCC_RST   8'h03
`define PCS_PCC_UNDIV 8'h80
`define PCS_PCC_WMASK 8'hEF

// field positions
`define PCS_CTL_ON    0
`define PCS_CTL_SEL   1
`define PCS_PCC_FRC   7
`define PCS_PCC_MCK   6
`define PCS_PCC_MFRC  5
`define PCS_PCC_CLS   4
`define PCS_PCC_SUB   3
`define PCS_PCC_DIVH  2
`define PCS_STAT_ERR  0

// timing: oscillation stabilisation time and the clock period
`define PCS_CLK_NS    (10)
`define PCS_LOCK_NS   100000
`define PCS_LOCK_CYC  ((`PCS_LOCK_NS + (`PCS_CLK_NS) - 1) / (`PCS_CLK_NS))
`define PCS_CNT_W     16
`define PCS_CNT_ONE   16'h0001
`define PCS_CNT_ZERO  16'h0000

`endif

// ### include/pcs_pkg.sv
// types shared by the pll clock select control block
package pcs_pkg;
	// protection unlock sequence state, gray along idle -> armed
	typedef enum logic [0:0] {
		PCS_PROT_IDLE  = 1'b0,
		PCS_PROT_ARMED = 1'b1
	} pcs_prot_e;
	typedef logic [7:0] pcs_byte_t;
endpackage

// ### verilog/pcs_lock_timer.sv
// pll stabilisation timer feeding the lock flag
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"
module pcs_lock_timer #(
	parameter int LOCK_CYC = `PCS_LOCK_CYC
) (
	input  wire logic clk_sys,  // system clock
	input  wire logic reset_n,  // async reset, active low
	input  wire logic clk_en,   // freezes state while low
	input  wire logic pll_on,   // pll running
	output logic      locked    // stabilisation time elapsed
);
	localparam logic [`PCS_CNT_W-1:0] LAST = `PCS_CNT_W'(LOCK_CYC - 1);

	logic [`PCS_CNT_W-1:0] cnt_ff;
	logic                  locked_ff;

	// count while the pll runs until lock, then hold; restart whenever it is stopped
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff    <= `PCS_CNT_ZERO;
			locked_ff <= 1'b0;
		end else if (clk_en) begin
			if (!pll_on) begin
				cnt_ff    <= `PCS_CNT_ZERO;
				locked_ff <= 1'b0;
			end else if (!locked_ff) begin
				cnt_ff    <= cnt_ff + `PCS_CNT_ONE;
				locked_ff <= (cnt_ff == LAST);
			end
		end
	end

	assign locked = locked_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_lock_drop_off: assert property (
		clk_en && !pll_on |=> !locked_ff)
		else $error("lock stays set with pll stopped");
	a_lock_on_count: assert property (
		clk_en && pll_on && !locked_ff && cnt_ff == LAST |=> locked_ff)
		else $error("lock not set at end of count");
endmodule // pcs_lock_timer
`default_nettype wire

// ### testbench/pcs_clock_ctrl_test.sv
// self-checking bench for the pll clock select control block
`timescale 1ns/10ps
`default_nettype none
`include "pcs_cfg.svh"
module pcs_clock_ctrl_test
	import pcs_pkg::*;
;
	logic               clk_sys;
	logic               reset_n;
	logic               clk_en;
	logic [`PCS_AW-1:0] reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_rdata;
	logic               pll_run;
	logic               src_pll;
	logic               mult8;
	logic [2:0]         cpu_clk_div;
	logic               on_subclk;
	logic               osc_stop;
	logic               main_fb;
	logic               sub_fb;
	int                 bad_count;
	int                 n_checks;
	int                 cyc;
	pcs_byte_t          p;
	pcs_byte_t          m;

	// block under test, lock time cut down to keep the run short
	pcs_clock_ctrl #(.LOCK_CYC(8)) u_pcs_clock_ctrl (
		.clk_sys                  (clk_sys),
		.reset_n                  (reset_n),
		.clk_en                   (clk_en),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.pll_run                  (pll_run),
		.sys_clk_src_pll          (src_pll),
		.pll_mult8                (mult8),
		.cpu_clk_div              (cpu_clk_div),
		.cpu_on_subclk            (on_subclk),
		.main_osc_stop            (osc_stop),
		.main_fb_disable          (main_fb),
		.subclock_feedback_disable(sub_fb)
	);

	// expected readback of the processor clock control register
	function automatic pcs_byte_t exp_pcc(input pcs_byte_t v);
		return (v & `PCS_PCC_WMASK) | {3'h0, v[3], 4'h0};
	endfunction

	// compare a register byte
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: byte %h, want %h", $time, got, exp);
		end
	endtask

	// compare a single output bit
	task automatic cmp_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: bit %b, want %b", $time, got, exp);
		end
	endtask

	// one write cycle followed by an idle cycle
	task automatic wr(input logic [`PCS_AW-1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	// one read cycle, data checked in the cycle after it
	task automatic rd(input logic [`PCS_AW-1:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		cmp_byte(reg_rdata, e);
		@(posedge clk_sys);
	endtask

	// settled clock control outputs against expected pll and pcc state
	task automatic outs(input logic r, input logic s, input logic x8,
			input pcs_byte_t v);
		#1;
		cmp_bit(pll_run, r);
		cmp_bit(src_pll, s);
		cmp_bit(mult8, x8);
		cmp_byte({5'h00, cpu_clk_div}, {5'h00, v[2:0]});
		cmp_bit(on_subclk, v[3]);
		cmp_bit(main_fb, v[5]);
		cmp_bit(osc_stop, v[6]);
		cmp_bit(sub_fb, v[7]);
	endtask

	// poll the lock flag with a bounded number of reads
	task automatic wait_lock();
		int n;
		for (n = 0; n < 40; n++) begin
			reg_addr <= `PCS_A_LOCK;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1;
			if (reg_rdata === `PCS_LOCK_DONE) break;
			@(posedge clk_sys);
		end
		cmp_bit(n < 40, 1'b1);
		@(posedge clk_sys);
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// 100 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// hang guard, far above the expected run length
	initial cyc = 0;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			wrap_up();
		end
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		reg_addr = '0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		bad_count = 0;
		n_checks = 0;
		void'($urandom(32'h1F794F34));
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(`PCS_A_LOCK, `PCS_LOCK_WAIT);
		rd(`PCS_A_CTL, `PCS_CTL_RST);
		rd(`PCS_A_MUL, `PCS_MUL_RST);
		rd(`PCS_A_PCC, `PCS_PCC_RST);
		outs(1'b1, 1'b0, 1'b0, `PCS_PCC_RST);
		done("reset");
		wait_lock();
		wr(`PCS_A_LOCK, 8'h55);
		rd(`PCS_A_LOCK, `PCS_LOCK_DONE);
		done("lock");
		// stop the pll straight from reset state, then change the factor
		wr(`PCS_A_CTL, 8'h00);
		rd(`PCS_A_LOCK, `PCS_LOCK_WAIT);
		wr(`PCS_A_MUL, `PCS_MUL_X8);
		rd(`PCS_A_MUL, `PCS_MUL_RST);
		rd(`PCS_A_STAT, 8'h01);
		wr(`PCS_A_STAT, 8'h01);
		rd(`PCS_A_STAT, 8'h00);
		wr(`PCS_A_CMD, 8'h0A);
		wr(`PCS_A_MUL, `PCS_MUL_X8);
		rd(`PCS_A_MUL, `PCS_MUL_RST);
		wr(`PCS_A_CMD, `PCS_MUL_X8);
		wr(`PCS_A_MUL, `PCS_MUL_X8);
		rd(`PCS_A_MUL, `PCS_MUL_X8);
		outs(1'b0, 1'b0, 1'b1, `PCS_PCC_RST);
		done("multiplier");
		// start, select, deselect and stop the pll in order
		wr(`PCS_A_CTL, 8'h01);
		wait_lock();
		wr(`PCS_A_CTL, 8'h03);
		outs(1'b1, 1'b1, 1'b1, `PCS_PCC_RST);
		rd(`PCS_A_CTL, 8'h03);
		wr(`PCS_A_CTL, 8'h01);
		outs(1'b1, 1'b0, 1'b1, `PCS_PCC_RST);
		repeat (8) @(posedge clk_sys);
		wr(`PCS_A_CTL, 8'h00);
		outs(1'b0, 1'b0, 1'b1, `PCS_PCC_RST);
		done("pll");
		// undivided clock, with a read between unlock and store
		wr(`PCS_A_CMD, `PCS_PCC_UNDIV);
		rd(`PCS_A_LOCK, `PCS_LOCK_WAIT);
		wr(`PCS_A_PCC, `PCS_PCC_UNDIV);
		outs(1'b0, 1'b0, 1'b1, `PCS_PCC_UNDIV);
		wr(`PCS_A_CMD, 8'h90);
		wr(`PCS_A_PCC, 8'h90);
		rd(`PCS_A_PCC, `PCS_PCC_UNDIV);
		done("pcc");
		// a write while the clock enable is low must not land
		clk_en <= 1'b0;
		wr(`PCS_A_CTL, 8'h03);
		clk_en <= 1'b1;
		rd(`PCS_A_CTL, 8'h00);
		outs(1'b0, 1'b0, 1'b1, `PCS_PCC_UNDIV);
		done("freeze");
		// random protected stores to both protected registers
		for (int i = 0; i < 8; i++) begin
			p = pcs_byte_t'($urandom);
			p[2:0] = 3'($urandom_range(5, 0));
			wr(`PCS_A_CMD, p);
			wr(`PCS_A_PCC, p);
			rd(`PCS_A_PCC, exp_pcc(p));
			m = ($urandom_range(1, 0) == 1) ? `PCS_MUL_X8 : pcs_byte_t'($urandom);
			wr(`PCS_A_CMD, m);
			wr(`PCS_A_MUL, m);
			rd(`PCS_A_MUL, m);
			outs(1'b0, 1'b0, m === `PCS_MUL_X8, p);
		end
		rd(3'h6, 8'h00);
		rd(3'h7, 8'h00);
		done("random");
		// second reset in mid-run brings back the lock, multiplier and processor clock reset values and the output reset state
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(`PCS_A_LOCK, `PCS_LOCK_WAIT);
		rd(`PCS_A_MUL, `PCS_MUL_RST);
		rd(`PCS_A_PCC, `PCS_PCC_RST);
		outs(1'b1, 1'b0, 1'b0, `PCS_PCC_RST);
		done("rereset");
		wrap_up();
	end
endmodule // pcs_clock_ctrl_test
`default_nettype wire
